// ===== hw/cpad_datapath.sv
// Arithmetic, multiply, divide and stack transfer datapath with its register file.
`timescale 1ns/1ps
`default_nettype none
module cpad_datapath
  import cpad_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Operation command.
  input wire logic op_valid_in,
  input wire logic [4:0] op_code_in,
  input wire logic [1:0] op_size_in,
  input wire logic [3:0] op_dst_in,
  input wire logic [3:0] op_src_in,
  input wire logic op_use_imm_in,
  input wire logic [31:0] op_imm_in,
  input wire logic [2:0] op_count_in,
  // Operation status.
  output logic op_ready_out,
  output logic op_done_out,
  output logic op_illegal_out,
  output logic [7:0] cc_out,
  // Register file load and view.
  input wire logic load_en_in,
  input wire logic [2:0] load_idx_in,
  input wire logic [31:0] load_data_in,
  input wire logic [2:0] view_idx_in,
  output logic [31:0] view_data_out,
  // Stack memory port.
  output logic mem_req_out,
  output logic mem_we_out,
  output logic mem_long_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  input wire logic [31:0] mem_rdata_in,
  input wire logic mem_ack_in
);
  import cpad_pkg::*;

  cpad_regs_type s_reg;
  cpad_regs_type s_next;

  // Reads a register view: byte index bit 3 picks low byte, word bit 3 picks upper half.
  function automatic logic [31:0] reg_get(input logic [7:0][31:0] r, input logic [3:0] i,
                                          input logic [1:0] sz);
    logic [31:0] w;
    w = r[i[2:0]];
    case (sz)
      SZ_B: reg_get = i[3] ? {24'h0, w[7:0]} : {24'h0, w[15:8]};
      SZ_W: reg_get = i[3] ? {16'h0, w[31:16]} : {16'h0, w[15:0]};
      default: reg_get = w;
    endcase
  endfunction

  // Returns the whole longword after writing one view of it.
  function automatic logic [31:0] reg_put(input logic [31:0] w, input logic [3:0] i,
                                          input logic [1:0] sz, input logic [31:0] v);
    reg_put = w;
    case (sz)
      SZ_B:
      begin
        if (i[3]) reg_put[7:0] = v[7:0];
        else reg_put[15:8] = v[7:0];
      end
      SZ_W:
      begin
        if (i[3]) reg_put[31:16] = v[15:0];
        else reg_put[15:0] = v[15:0];
      end
      default: reg_put = v;
    endcase
  endfunction

  // Sized add or subtract with carry in; returns {H, N, Z, V, C, result}.
  function automatic logic [36:0] arith(input logic [31:0] a, input logic [31:0] b,
                                        input logic cin, input logic sub, input logic [1:0] sz);
    logic [31:0] m;
    logic [31:0] hm;
    logic [32:0] t;
    logic [32:0] h;
    logic [31:0] r;
    logic sa;
    logic sb;
    logic sr;
    logic v;
    case (sz)
      SZ_B: m = 32'h0000_00ff;
      SZ_W: m = 32'h0000_ffff;
      default: m = 32'hffff_ffff;
    endcase
    hm = m >> 4;
    // Masked operands make any bit above the size a carry or borrow.
    t = sub ? {1'b0, a & m} - {1'b0, b & m} - {32'h0, cin}
            : {1'b0, a & m} + {1'b0, b & m} + {32'h0, cin};
    h = sub ? {1'b0, a & hm} - {1'b0, b & hm} - {32'h0, cin}
            : {1'b0, a & hm} + {1'b0, b & hm} + {32'h0, cin};
    r = t[31:0] & m;
    sa = |(a & (m ^ (m >> 1)));
    sb = |(b & (m ^ (m >> 1)));
    sr = |(r & (m ^ (m >> 1)));
    v = sub ? ((sa != sb) && (sr != sa)) : ((sa == sb) && (sr != sa));
    arith = {|(h & ~{1'b0, hm}), sr, (r == 32'h0), v, |(t & ~{1'b0, m}), r};
  endfunction

  // Next-state logic for commands, flags and the stack sequencer.
  always_comb
  begin
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] dw;
    logic [31:0] sp;
    logic [31:0] res;
    logic [36:0] ar;
    logic [7:0] corr;
    logic [1:0] asz;
    logic sub;
    logic cin;
    logic bad;
    a = 32'h0;
    b = 32'h0;
    dw = 32'h0;
    sp = s_reg.regs[SP_IDX];
    res = 32'h0;
    ar = 37'h0;
    corr = 8'h0;
    asz = op_size_in;
    sub = 1'b0;
    cin = 1'b0;
    bad = 1'b0;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.illegal = 1'b0;
    s_next.view = s_reg.regs[view_idx_in];
    // Direct register loading, overridden by a command result to the same register.
    if (load_en_in) s_next.regs[load_idx_in] = load_data_in;
    case (s_reg.st)
      CPAD_IDLE:
      begin
        // Operand fetch and shared adder set-up.
        a = reg_get(s_reg.regs, op_dst_in, op_size_in);
        b = op_use_imm_in ? op_imm_in : reg_get(s_reg.regs, op_src_in, op_size_in);
        dw = reg_get(s_reg.regs, op_dst_in, (op_size_in == SZ_B) ? SZ_W : SZ_L);
        sub = (op_code_in == OP_SUB) || (op_code_in == OP_SBB) || (op_code_in == OP_CMP) ||
              (op_code_in == OP_DEC) || (op_code_in == OP_ASUB);
        cin = ((op_code_in == OP_ADC) || (op_code_in == OP_SBB)) & s_reg.cc[CC_C];
        if ((op_code_in == OP_INC) || (op_code_in == OP_DEC) ||
            (op_code_in == OP_ADDS) || (op_code_in == OP_ASUB))
          b = {29'h0, op_imm_in[2:0]};
        if ((op_code_in == OP_ADDS) || (op_code_in == OP_ASUB))
          asz = SZ_L;
        ar = arith(a, b, cin, sub, asz);
        if (op_valid_in)
        begin
          // Reject sizes beyond longword for every operation.
          bad = (op_size_in == 2'h3);
          case (op_code_in)
            OP_ADD, OP_SUB, OP_CMP, OP_ADC, OP_SBB:
            begin
              if ((op_code_in == OP_SUB) && (op_size_in == SZ_B) && op_use_imm_in) bad = 1'b1;
              if (((op_code_in == OP_ADC) || (op_code_in == OP_SBB)) && (op_size_in != SZ_B))
                bad = 1'b1;
              if (!bad)
              begin
                if (op_code_in != OP_CMP)
                  s_next.regs[op_dst_in[2:0]] =
                    reg_put(s_reg.regs[op_dst_in[2:0]], op_dst_in, op_size_in, ar[31:0]);
                s_next.cc[CC_H] = ar[36];
                s_next.cc[CC_N] = ar[35];
                s_next.cc[CC_Z] = ar[34];
                s_next.cc[CC_V] = ar[33];
                s_next.cc[CC_C] = ar[32];
                // Carry forms only clear zero, so a chain tests zero across all bytes.
                if ((op_code_in == OP_ADC) || (op_code_in == OP_SBB))
                  s_next.cc[CC_Z] = ar[34] & s_reg.cc[CC_Z];
              end
            end
            OP_INC, OP_DEC:
            begin
              bad = bad || (op_imm_in[2:0] != 3'h1 && (op_imm_in[2:0] != 3'h2 ||
                    op_size_in == SZ_B));
              if (!bad)
              begin
                s_next.regs[op_dst_in[2:0]] =
                  reg_put(s_reg.regs[op_dst_in[2:0]], op_dst_in, op_size_in, ar[31:0]);
                s_next.cc[CC_N] = ar[35];
                s_next.cc[CC_Z] = ar[34];
                s_next.cc[CC_V] = ar[33];
              end
            end
            OP_ADDS, OP_ASUB:
            begin
              bad = bad || ((op_imm_in[2:0] != 3'h1) && (op_imm_in[2:0] != 3'h2) &&
                    (op_imm_in[2:0] != 3'h4));
              if (!bad) s_next.regs[op_dst_in[2:0]] = ar[31:0];
            end
            OP_BCDA, OP_BCDS:
            begin
              bad = (op_size_in != SZ_B);
              if (op_code_in == OP_BCDA)
              begin
                if (s_reg.cc[CC_C] || (a[7:0] > BCD_LIM)) corr = BCD_HI;
                if (s_reg.cc[CC_H] || (a[3:0] > BCD_DIG)) corr = corr | BCD_LO;
                res = {24'h0, a[7:0] + corr};
              end
              else
              begin
                if (s_reg.cc[CC_C]) corr = BCD_HI;
                if (s_reg.cc[CC_H]) corr = corr | BCD_LO;
                res = {24'h0, a[7:0] - corr};
              end
              if (!bad)
              begin
                s_next.regs[op_dst_in[2:0]] =
                  reg_put(s_reg.regs[op_dst_in[2:0]], op_dst_in, SZ_B, res);
                s_next.cc[CC_N] = res[7];
                s_next.cc[CC_Z] = (res[7:0] == 8'h0);
                if (op_code_in == OP_BCDA) s_next.cc[CC_C] = s_reg.cc[CC_C] | corr[6];
              end
            end
            OP_MULU, OP_MULS, OP_DIVU:
            begin
              bad = (op_size_in == SZ_L) || bad;
              if (op_code_in == OP_MULU)
                res = (op_size_in == SZ_B) ? {16'h0, {8'h0, dw[7:0]} * {8'h0, b[7:0]}}
                                           : {16'h0, dw[15:0]} * {16'h0, b[15:0]};
              else if (op_code_in == OP_MULS)
                res = (op_size_in == SZ_B)
                      ? {16'h0, {{8{dw[7]}}, dw[7:0]} * {{8{b[7]}}, b[7:0]}}
                      : {{16{dw[15]}}, dw[15:0]} * {{16{b[15]}}, b[15:0]};
              else if (b[15:0] != 16'h0)
                res = (op_size_in == SZ_B)
                      ? {16'h0, 8'(dw[15:0] % {8'h0, b[7:0]}), 8'(dw[15:0] / {8'h0, b[7:0]})}
                      : {16'(dw % {16'h0, b[15:0]}), 16'(dw / {16'h0, b[15:0]})};
              if (!bad)
              begin
                if (op_code_in == OP_DIVU)
                begin
                  s_next.cc[CC_N] = (op_size_in == SZ_B) ? b[7] : b[15];
                  s_next.cc[CC_Z] = (op_size_in == SZ_B) ? (b[7:0] == 8'h0)
                                                           : (b[15:0] == 16'h0);
                end
                else if (op_code_in == OP_MULS)
                begin
                  s_next.cc[CC_N] = (op_size_in == SZ_B) ? res[15] : res[31];
                  s_next.cc[CC_Z] = (op_size_in == SZ_B) ? (res[15:0] == 16'h0)
                                                           : (res == 32'h0);
                end
                // A zero divisor leaves the destination untouched.
                if ((op_code_in != OP_DIVU) || !s_next.cc[CC_Z])
                  s_next.regs[op_dst_in[2:0]] = reg_put(s_reg.regs[op_dst_in[2:0]], op_dst_in,
                    (op_size_in == SZ_B) ? SZ_W : SZ_L, res);
              end
            end
            OP_ZEXT:
            begin
              bad = (op_size_in == SZ_B) || bad;
              res = (op_size_in == SZ_W) ? {24'h0, a[7:0]} : {16'h0, a[15:0]};
              if (!bad)
              begin
                s_next.regs[op_dst_in[2:0]] =
                  reg_put(s_reg.regs[op_dst_in[2:0]], op_dst_in, op_size_in, res);
                s_next.cc[CC_N] = 1'b0;
                s_next.cc[CC_Z] = (res == 32'h0);
                s_next.cc[CC_V] = 1'b0;
              end
            end
            OP_PUSH, OP_POP, OP_MPSH, OP_MPOP:
            begin
              s_next.multi = (op_code_in == OP_MPSH) || (op_code_in == OP_MPOP);
              s_next.lng = s_next.multi || (op_size_in == SZ_L);
              s_next.we = (op_code_in == OP_PUSH) || (op_code_in == OP_MPSH);
              s_next.dst = op_dst_in;
              s_next.sz = op_size_in;
              s_next.cnt = s_next.multi ? 3'(op_count_in - 3'h1) : 3'h0;
              s_next.cur = (op_code_in == OP_MPOP) ? 3'(op_dst_in[2:0] + op_count_in - 3'h1)
                                                   : op_dst_in[2:0];
              bad = bad || (s_next.multi ? ((op_count_in < MULTI_MIN) ||
                    (op_count_in > MULTI_MAX)) : ((op_size_in != SZ_W) && (op_size_in != SZ_L)));
              if (s_next.we) sp = sp - (s_next.lng ? STEP_L : STEP_W);
              s_next.wdata = s_next.multi ? s_reg.regs[op_dst_in[2:0]] : a;
              s_next.addr = sp;
              if (!bad)
              begin
                s_next.regs[SP_IDX] = sp;
                s_next.st = CPAD_MEM;
              end
            end
            default:
              bad = 1'b1;
          endcase
          s_next.illegal = bad;
          s_next.done = !bad && (s_next.st == CPAD_IDLE);
        end
      end
      CPAD_MEM:
      begin
        if (mem_ack_in)
        begin
          if (!s_reg.we)
          begin
            if (s_reg.multi) s_next.regs[s_reg.cur] = mem_rdata_in;
            else
              s_next.regs[s_reg.dst[2:0]] = reg_put(s_reg.regs[s_reg.dst[2:0]], s_reg.dst,
                s_reg.sz, mem_rdata_in);
            sp = sp + (s_reg.lng ? STEP_L : STEP_W);
          end
          if (s_reg.cnt != 3'h0)
          begin
            s_next.cnt = 3'(s_reg.cnt - 3'h1);
            if (s_reg.we)
            begin
              s_next.cur = 3'(s_reg.cur + 3'h1);
              sp = sp - STEP_L;
              s_next.wdata = s_next.regs[s_next.cur];
            end
            else
              s_next.cur = 3'(s_reg.cur - 3'h1);
            s_next.addr = sp;
          end
          else
          begin
            s_next.st = CPAD_IDLE;
            s_next.done = 1'b1;
          end
          s_next.regs[SP_IDX] = sp;
        end
      end
      default:
        s_next.st = CPAD_IDLE;
    endcase
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      s_reg <= '0;
      s_reg.cc <= CC_RESET;
      s_reg.st <= CPAD_IDLE;
    end
    else
      s_reg <= s_next;
  end

  // Outputs; handshakes are decoded from the state, data comes from flops.
  assign op_ready_out = (s_reg.st == CPAD_IDLE);
  assign op_done_out = s_reg.done;
  assign op_illegal_out = s_reg.illegal;
  assign cc_out = s_reg.cc;
  assign view_data_out = s_reg.view;
  assign mem_req_out = (s_reg.st == CPAD_MEM);
  assign mem_we_out = s_reg.we;
  assign mem_long_out = s_reg.lng;
  assign mem_addr_out = s_reg.addr;
  assign mem_wdata_out = s_reg.wdata;
endmodule
`default_nettype wire

// ===== hw/cpad_pkg.sv
// Package with constants, opcodes and state types of the arithmetic and stack datapath.
package cpad_pkg;
  // Operand sizes.
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_W = 2'h1;
  localparam logic [1:0] SZ_L = 2'h2;
  // Operation codes presented on the command port.
  localparam logic [4:0] OP_ADD = 5'h00;
  localparam logic [4:0] OP_SUB = 5'h01;
  localparam logic [4:0] OP_ADC = 5'h02;
  localparam logic [4:0] OP_SBB = 5'h03;
  localparam logic [4:0] OP_CMP = 5'h04;
  localparam logic [4:0] OP_INC = 5'h05;
  localparam logic [4:0] OP_DEC = 5'h06;
  localparam logic [4:0] OP_ADDS = 5'h07;
  localparam logic [4:0] OP_ASUB = 5'h08;
  localparam logic [4:0] OP_BCDA = 5'h09;
  localparam logic [4:0] OP_BCDS = 5'h0a;
  localparam logic [4:0] OP_MULU = 5'h0b;
  localparam logic [4:0] OP_MULS = 5'h0c;
  localparam logic [4:0] OP_DIVU = 5'h0d;
  localparam logic [4:0] OP_ZEXT = 5'h0e;
  localparam logic [4:0] OP_POP = 5'h0f;
  localparam logic [4:0] OP_PUSH = 5'h10;
  localparam logic [4:0] OP_MPOP = 5'h11;
  localparam logic [4:0] OP_MPSH = 5'h12;
  localparam logic [4:0] OP_PSLD = 5'h13;
  localparam logic [4:0] OP_PSST = 5'h14;
  // Condition code bit positions.
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_H = 5;
  localparam logic [7:0] CC_RESET = 8'h00;
  // Steps, stack pointer index and multi-register list limits.
  localparam logic [31:0] STEP_W = 32'h2;
  localparam logic [31:0] STEP_L = 32'h4;
  localparam logic [2:0] SP_IDX = 3'h7;
  localparam logic [2:0] MULTI_MIN = 3'h2;
  localparam logic [2:0] MULTI_MAX = 3'h4;
  // Decimal adjust constants.
  localparam logic [7:0] BCD_LIM = 8'h99;
  localparam logic [3:0] BCD_DIG = 4'h9;
  localparam logic [7:0] BCD_LO = 8'h06;
  localparam logic [7:0] BCD_HI = 8'h60;
  // Sequencer states, one-hot.
  typedef enum logic [1:0] {
    CPAD_IDLE = 2'b01,
    CPAD_MEM = 2'b10
  } cpad_state_type;
  // Whole state of the datapath.
  typedef struct packed {
    logic [7:0][31:0] regs;
    logic [7:0] cc;
    cpad_state_type st;
    logic [2:0] cnt;
    logic [2:0] cur;
    logic [3:0] dst;
    logic [1:0] sz;
    logic multi;
    logic we;
    logic lng;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic done;
    logic illegal;
    logic [31:0] view;
  } cpad_regs_type;
endpackage

// ===== testbench/cpad_datapath_assertions.sv
// Port-level checks on the arithmetic and stack datapath.
`timescale 1ns/1ps
`default_nettype none
module cpad_datapath_assertions (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Command side.
  input wire logic op_valid_in,
  input wire logic [4:0] op_code_in,
  input wire logic [1:0] op_size_in,
  input wire logic op_use_imm_in,
  input wire logic [31:0] op_imm_in,
  input wire logic op_ready_out,
  input wire logic op_done_out,
  input wire logic op_illegal_out,
  input wire logic [7:0] cc_out,
  // Stack memory side.
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic mem_ack_in
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // High when a command is accepted at this edge.
  logic take;
  assign take = op_valid_in && op_ready_out;
  AST_ALU_ANSWER: assert property (take && op_code_in < 5'h0f |=> op_done_out != op_illegal_out)
    else $error("ALU command did not give exactly one answer");
  AST_PERIPH_REJECT: assert property (take && (op_code_in == 5'h13 || op_code_in == 5'h14)
    |=> op_illegal_out && !op_done_out) else $error("Peripheral byte move was not rejected");
  AST_BYTE_STEP_ONE: assert property (take && (op_code_in == 5'h05 || op_code_in == 5'h06)
    && op_size_in == 2'h0 && op_imm_in[2:0] == 3'h2 |=> op_illegal_out)
    else $error("Byte step of two was accepted");
  AST_NO_BYTE_SUB_IMM: assert property (take && op_code_in == 5'h01 && op_size_in == 2'h0
    && op_use_imm_in |=> op_illegal_out) else $error("Byte subtract of immediate was accepted");
  AST_ADDR_STEP: assert property (take && (op_code_in == 5'h07 || op_code_in == 5'h08)
    && op_size_in == 2'h2 && !(op_imm_in[2:0] inside {3'h1, 3'h2, 3'h4}) |=> op_illegal_out)
    else $error("Address step outside one, two, four was accepted");
  AST_REJECT_KEEPS_FLAGS: assert property (op_illegal_out |-> $stable(cc_out))
    else $error("Rejected command changed the flags");
  AST_READY_VS_REQ: assert property (op_ready_out != mem_req_out)
    else $error("Ready and stack request overlap");
  AST_REQ_HOLDS: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("Stack request dropped or moved before its answer");
  AST_MULTI_PUSH_STEP: assert property (mem_req_out && mem_ack_in && mem_we_out ##1 mem_req_out
    |-> mem_addr_out == $past(mem_addr_out) - 32'h4) else $error("Multi push address step wrong");
  AST_MULTI_POP_STEP: assert property (mem_req_out && mem_ack_in && !mem_we_out ##1 mem_req_out
    |-> mem_addr_out == $past(mem_addr_out) + 32'h4) else $error("Multi pop address step wrong");
  AST_STACK_DONE: assert property (mem_req_out && mem_ack_in ##1 !mem_req_out |-> op_done_out)
    else $error("Stack transfer ended without done");
endmodule
bind cpad_datapath cpad_datapath_assertions cpad_datapath_assertions_i (.clk_sys_in(clk_sys_in),
  .nrst_in(nrst_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in), .op_size_in(op_size_in),
  .op_use_imm_in(op_use_imm_in), .op_imm_in(op_imm_in), .op_ready_out(op_ready_out),
  .op_done_out(op_done_out), .op_illegal_out(op_illegal_out), .cc_out(cc_out),
  .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
  .mem_ack_in(mem_ack_in));
`default_nettype wire

// ===== testbench/cpad_datapath_test.sv
// Self-checking bench for the arithmetic and stack datapath.
`timescale 1ns/1ps
`default_nettype none
module cpad_datapath_test;
  import cpad_pkg::*;
  // One table row: command, start values of registers 1 and 2, expected register 1 and flags.
  typedef struct packed {
    logic [4:0] c;
    logic [1:0] s;
    logic [3:0] d;
    logic [3:0] r;
    logic u;
    logic [7:0] im;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] e;
    logic [7:0] m;
    logic [7:0] v;
    logic ill;
  } cpad_row_type;
  // Stimulus, all given a value at time zero.
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, op_valid_in = 1'b0, op_use_imm_in = 1'b0;
  logic load_en_in = 1'b0, mem_ack_in = 1'b0;
  logic [4:0] op_code_in = 5'h0;
  logic [1:0] op_size_in = 2'h0;
  logic [3:0] op_dst_in = 4'h0, op_src_in = 4'h0;
  logic [2:0] op_count_in = 3'h2, load_idx_in = 3'h0, view_idx_in = 3'h0;
  logic [31:0] op_imm_in = 32'h0, load_data_in = 32'h0, mem_rdata_in = 32'h0;
  // Observed outputs.
  logic op_ready_out, op_done_out, op_illegal_out, mem_req_out, mem_we_out, mem_long_out;
  logic [7:0] cc_out;
  logic [31:0] view_data_out, mem_addr_out, mem_wdata_out;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  // Ordinary cases, run in order since carry and half-carry chain between rows.
  cpad_row_type rows [27] = '{
    '{5'h00,2'h0,4'h9,4'ha,1'b0,8'h0,32'hff,32'h1,32'h0,8'h2f,8'h25,1'b0},
    '{5'h02,2'h0,4'h9,4'ha,1'b1,8'h10,32'h5,32'h0,32'h16,8'h04,8'h0,1'b0},
    '{5'h04,2'h0,4'h9,4'ha,1'b0,8'h0,32'h1,32'h2,32'h1,8'h0f,8'h09,1'b0},
    '{5'h03,2'h0,4'h9,4'ha,1'b0,8'h0,32'h20,32'h5,32'h1a,8'h04,8'h0,1'b0},
    '{5'h01,2'h0,4'h9,4'ha,1'b1,8'h1,32'h33,32'h0,32'h33,8'h0,8'h0,1'b1},
    '{5'h05,2'h1,4'h1,4'h2,1'b0,8'h2,32'h1234ffff,32'h0,32'h12340001,8'h0e,8'h0,1'b0},
    '{5'h06,2'h0,4'h9,4'ha,1'b0,8'h2,32'h44,32'h0,32'h44,8'h0,8'h0,1'b1},
    '{5'h05,2'h0,4'h9,4'ha,1'b0,8'h1,32'h7f,32'h0,32'h80,8'h0e,8'h0a,1'b0},
    '{5'h07,2'h2,4'h1,4'h2,1'b0,8'h4,32'hfffffffe,32'h0,32'h2,8'h0,8'h0,1'b0},
    '{5'h08,2'h2,4'h1,4'h2,1'b0,8'h1,32'h0,32'h0,32'hffffffff,8'h0,8'h0,1'b0},
    '{5'h00,2'h0,4'h9,4'ha,1'b0,8'h0,32'h15,32'h27,32'h3c,8'h2f,8'h0,1'b0},
    '{5'h09,2'h0,4'h9,4'ha,1'b0,8'h0,32'h3c,32'h0,32'h42,8'h0c,8'h0,1'b0},
    '{5'h01,2'h0,4'h9,4'ha,1'b0,8'h0,32'h42,32'h15,32'h2d,8'h2f,8'h20,1'b0},
    '{5'h0a,2'h0,4'h9,4'ha,1'b0,8'h0,32'h2d,32'h0,32'h27,8'h0c,8'h0,1'b0},
    '{5'h0b,2'h0,4'h1,4'ha,1'b0,8'h0,32'habcd00ff,32'hff,32'habcdfe01,8'h0,8'h0,1'b0},
    '{5'h0b,2'h1,4'h1,4'h2,1'b0,8'h0,32'hffff,32'hffff,32'hfffe0001,8'h0,8'h0,1'b0},
    '{5'h0c,2'h0,4'h1,4'ha,1'b0,8'h0,32'hff,32'h2,32'hfffe,8'h0c,8'h08,1'b0},
    '{5'h0c,2'h1,4'h1,4'h2,1'b0,8'h0,32'h8000,32'h2,32'hffff0000,8'h0c,8'h08,1'b0},
    '{5'h0d,2'h0,4'h1,4'ha,1'b0,8'h0,32'h64,32'h7,32'h20e,8'h0c,8'h0,1'b0},
    '{5'h0d,2'h1,4'h1,4'h2,1'b0,8'h0,32'h10003,32'h2,32'h18001,8'h0c,8'h0,1'b0},
    '{5'h0d,2'h0,4'h1,4'ha,1'b0,8'h0,32'h64,32'h0,32'h64,8'h0c,8'h04,1'b0},
    '{5'h0e,2'h1,4'h1,4'h2,1'b0,8'h0,32'h1234abcd,32'h0,32'h123400cd,8'h0e,8'h0,1'b0},
    '{5'h0e,2'h2,4'h1,4'h2,1'b0,8'h0,32'h1234abcd,32'h0,32'habcd,8'h0e,8'h0,1'b0},
    '{5'h05,2'h1,4'h9,4'h2,1'b0,8'h1,32'h1ffff,32'h0,32'h2ffff,8'h0,8'h0,1'b0},
    '{5'h00,2'h0,4'h1,4'ha,1'b0,8'h0,32'h1000,32'h5,32'h1500,8'h0,8'h0,1'b0},
    '{5'h0e,2'h0,4'h1,4'h2,1'b0,8'h0,32'h66,32'h0,32'h66,8'h0,8'h0,1'b1},
    '{5'h13,2'h0,4'h9,4'ha,1'b0,8'h0,32'h77,32'h0,32'h77,8'h0,8'h0,1'b1}};
  cpad_datapath cpad_datapath_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in), .op_size_in(op_size_in),
    .op_dst_in(op_dst_in), .op_src_in(op_src_in), .op_use_imm_in(op_use_imm_in),
    .op_imm_in(op_imm_in), .op_count_in(op_count_in), .op_ready_out(op_ready_out),
    .op_done_out(op_done_out), .op_illegal_out(op_illegal_out), .cc_out(cc_out),
    .load_en_in(load_en_in), .load_idx_in(load_idx_in), .load_data_in(load_data_in),
    .view_idx_in(view_idx_in), .view_data_out(view_data_out), .mem_req_out(mem_req_out),
    .mem_we_out(mem_we_out), .mem_long_out(mem_long_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in));
  // Clock of 50 ns period.
  always #25 clk_sys_in = ~clk_sys_in;
  // Cuts a hung run short; the whole run needs well under this many cycles.
  always @(posedge clk_sys_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Compares one value, flags being zero-extended so unknowns still fail.
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares = compares + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Moves to just after the next rising edge, where inputs change.
  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic reset_dut();
    nrst_in = 1'b0;
    repeat (3) tick();
    nrst_in = 1'b1;
  endtask
  task automatic load(input logic [2:0] idx, input logic [31:0] data);
    load_en_in = 1'b1;
    load_idx_in = idx;
    load_data_in = data;
    tick();
    load_en_in = 1'b0;
  endtask
  // The view is registered, so it shows the register one edge after selection.
  task automatic view(input logic [2:0] idx, input logic [31:0] exp);
    view_idx_in = idx;
    tick();
    chk32("view", exp, view_data_out);
  endtask
  task automatic cmd(input logic [4:0] c, input logic [1:0] s, input logic [3:0] d,
                     input logic [3:0] r, input logic u, input logic [31:0] im, input logic [2:0] n);
    op_valid_in = 1'b1;
    op_code_in = c;
    op_size_in = s;
    op_dst_in = d;
    op_src_in = r;
    op_use_imm_in = u;
    op_imm_in = im;
    op_count_in = n;
    tick();
    op_valid_in = 1'b0;
  endtask
  // Answers one stack access after a one-cycle stall and checks what it carried.
  task automatic serve(input logic we, input logic lg, input logic [31:0] addr,
                       input logic [31:0] wd, input logic [31:0] rd);
    int n;
    n = 0;
    while (mem_req_out !== 1'b1 && n < 10)
    begin
      tick();
      n = n + 1;
    end
    chk32("mem_req", 32'h1, {31'h0, mem_req_out});
    chk32("mem_we", {31'h0, we}, {31'h0, mem_we_out});
    chk32("mem_long", {31'h0, lg}, {31'h0, mem_long_out});
    chk32("mem_addr", addr, mem_addr_out);
    if (we)
      chk32("mem_wdata", wd, mem_wdata_out);
    tick();
    mem_ack_in = 1'b1;
    mem_rdata_in = rd;
    tick();
    mem_ack_in = 1'b0;
    mem_rdata_in = ~rd;
  endtask
  initial
  begin
    cpad_row_type r;
    reset_dut();
    for (int i = 0; i < 27; i++)
    begin
      r = rows[i];
      load(3'h1, r.a);
      load(3'h2, r.b);
      cmd(r.c, r.s, r.d, r.r, r.u, {24'h0, r.im}, 3'h2);
      chk32("illegal", {31'h0, r.ill}, {31'h0, op_illegal_out});
      chk32("done", {31'h0, !r.ill}, {31'h0, op_done_out});
      view(3'h1, r.e);
      chk32("flags", {24'h0, r.v}, {24'h0, cc_out & r.m});
      $display("row %0d finished", i);
    end
    // A second reset clears registers and flags.
    reset_dut();
    view(3'h1, 32'h0);
    chk32("flags", 32'h0, {24'h0, cc_out});
    $display("reset test finished");
    // Single push of a longword, then pop of a word.
    load(SP_IDX, 32'h1000);
    load(3'h3, 32'hcafe1234);
    load(3'h4, 32'haaaa5555);
    load(3'h5, 32'h55667788);
    cmd(5'h10, SZ_L, 4'h3, 4'h0, 1'b0, 32'h0, 3'h2);
    serve(1'b1, 1'b1, 32'h0ffc, 32'hcafe1234, 32'h0);
    chk32("done", 32'h1, {31'h0, op_done_out});
    cmd(5'h0f, SZ_W, 4'h4, 4'h0, 1'b0, 32'h0, 3'h2);
    serve(1'b0, 1'b0, 32'h0ffc, 32'h0, 32'hffffbeef);
    view(3'h4, 32'haaaabeef);
    view(SP_IDX, 32'h0ffe);
    $display("push pop test finished");
    // Three-register push and pop, back to back on the memory port.
    load(SP_IDX, 32'h1000);
    cmd(5'h12, SZ_L, 4'h3, 4'h0, 1'b0, 32'h0, 3'h3);
    serve(1'b1, 1'b1, 32'h0ffc, 32'hcafe1234, 32'h0);
    serve(1'b1, 1'b1, 32'h0ff8, 32'haaaabeef, 32'h0);
    serve(1'b1, 1'b1, 32'h0ff4, 32'h55667788, 32'h0);
    view(SP_IDX, 32'h0ff4);
    cmd(5'h11, SZ_L, 4'h3, 4'h0, 1'b0, 32'h0, 3'h3);
    serve(1'b0, 1'b1, 32'h0ff4, 32'h0, 32'h11111111);
    serve(1'b0, 1'b1, 32'h0ff8, 32'h0, 32'h22222222);
    serve(1'b0, 1'b1, 32'h0ffc, 32'h0, 32'h33333333);
    view(3'h5, 32'h11111111);
    view(3'h3, 32'h33333333);
    view(SP_IDX, 32'h1000);
    // Refused stack and peripheral commands touch no memory.
    cmd(5'h12, SZ_L, 4'h3, 4'h0, 1'b0, 32'h0, 3'h5);
    chk32("illegal", 32'h1, {31'h0, op_illegal_out});
    cmd(5'h10, SZ_B, 4'h3, 4'h0, 1'b0, 32'h0, 3'h2);
    chk32("illegal", 32'h1, {31'h0, op_illegal_out});
    cmd(5'h14, SZ_B, 4'h9, 4'ha, 1'b0, 32'h0, 3'h2);
    chk32("illegal", 32'h1, {31'h0, op_illegal_out});
    $display("stack test finished");
    stop_test();
  end
endmodule
`default_nettype wire
